// ### event_irq_consts.vh
// Constants for the interrupt and event-transfer controller
`ifndef EVENT_IRQ_CONSTS_VH
`define EVENT_IRQ_CONSTS_VH

// Register byte offsets, one aligned 32-bit word each
`define SRC_CTL_BASE 8'h00
`define CHAN_CTL_BASE 8'h20
`define SRC_PTR_BASE 8'h40
`define DST_PTR_BASE 8'h60
`define IRQ_STATUS_OFF 8'h80
`define IRQ_ENABLE_OFF 8'h84
`define IRQ_CLEAR_OFF 8'h88
`define REGION_MASK 8'hE0

// Source control fields
`define SC_PRIO_LSB 0
`define SC_PRIO_MSB 3
`define SC_ENABLE 4
`define SC_EVT_SEL 5
`define SC_CHAN_LSB 6
`define SC_CHAN_MSB 8
`define SC_REQ 15

// Channel control fields
`define CC_COUNT_LSB 0
`define CC_COUNT_MSB 7
`define CC_WORD 8
`define CC_CONT 9
`define CC_SRC_INC 10
`define CC_DST_INC 11

// Block status bits
`define ST_XFER_DONE 0
`define ST_COUNT_ZERO 1
`define ST_CPU_TAKEN 2

// Reset values
`define SRC_CTL_RESET 16'h0000
`define CHAN_CTL_RESET 16'h0000
`define PTR_RESET 16'h0000
`define ST_RESET 3'h0

// Pointer steps
`define STEP_BYTE 16'h0001
`define STEP_WORD 16'h0002

`endif

// ### prio_pick.v
// Picks the highest-priority candidate among eight interrupt sources
`default_nettype none

module prio_pick (
  input wire [7:0] cand_i,   // Sources taking part in arbitration
  input wire [31:0] prio_i,  // Four priority bits per source
  output reg found_o,        // Some candidate present
  output reg [2:0] idx_o,    // Winning source number
  output reg [3:0] prio_o    // Winning priority
);

  integer k;

  ////////////////////////////////////////////////////////////////////////
  // Strictly greater keeps the lowest index on a tie
  always @* begin
    found_o = 1'b0;
    idx_o = 3'h0;
    prio_o = 4'h0;
    for (k = 0; k < 8; k = k + 1) begin
      if (cand_i[k] && (!found_o || prio_i[k*4 +: 4] > prio_o)) begin
        found_o = 1'b1;
        idx_o = k[2:0];
        prio_o = prio_i[k*4 +: 4];
      end
    end
  end

endmodule
`default_nettype wire

// ### event_irq_ctrl.v
// Interrupt arbiter with eight event-transfer channels and an Avalon-MM slave
//
// Decided for this implementation: the placing of the registers and the Avalon-MM interface to the registers.
`default_nettype none
`include "event_irq_consts.vh"

module event_irq_ctrl (
  input wire clk_i,                   // CPU clock, 100 MHz
  input wire rst_n_i,                 // Asynchronous reset, active low
  input wire [7:0] avs_address_i,     // Byte address
  input wire avs_read_i,              // Read request
  input wire avs_write_i,             // Write request
  input wire [31:0] avs_writedata_i,  // Write data
  input wire [3:0] avs_byteenable_i,  // Byte lanes
  output reg [31:0] avs_readdata_o,   // Read data
  output reg avs_waitrequest_o,       // Stall while high
  input wire [7:0] evt_i,             // Peripheral request pulses
  input wire [3:0] cpu_level_i,       // Current CPU priority level
  input wire cpu_ack_i,               // CPU accepts the interrupt
  output reg cpu_irq_o,               // Interrupt to the CPU
  output reg [2:0] cpu_vector_o,      // Requesting source number
  output reg stack_push_o,            // Save machine state pulse
  output reg xfer_valid_o,            // Move strobe, one cycle
  output reg [15:0] xfer_src_o,       // Segment-0 source address
  output reg [15:0] xfer_dst_o,       // Segment-0 destination address
  output reg xfer_word_o,             // Word move when high
  output reg irq_o                    // Block status interrupt
);

  ////////////////////////////////////////////////////////////////////////
  // Storage
  reg [1:0] rst_sync_reg;             // Reset release stages
  wire rst_n;                         // Synchronised reset
  reg [15:0] src_ctl_reg [0:7];       // Source control words
  reg [15:0] chan_ctl_reg [0:7];      // Channel count and mode
  reg [15:0] src_ptr_reg [0:7];       // Channel source pointers
  reg [15:0] dst_ptr_reg [0:7];       // Channel destination pointers
  reg [7:0] req_reg;                  // Request flags
  reg [7:0] req_next;
  reg [2:0] status_reg;               // Sticky block events
  reg [2:0] status_next;
  reg [2:0] enable_reg;               // Interrupt enables
  reg [31:0] rdata_next;
  integer i;                          // Arbitration loop index
  integer j;                          // Reset loop index

  assign rst_n = rst_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function [15:0] merge_be;           // Byte-lane merge into 16 bits
    input [15:0] old_v;
    input [31:0] new_v;
    input [3:0] be;
    begin
      merge_be = old_v;
      if (be[0]) merge_be[7:0] = new_v[7:0];
      if (be[1]) merge_be[15:8] = new_v[15:8];
    end
  endfunction

  function in_region;                 // Address inside a 8-word bank
    input [7:0] addr;
    input [7:0] base;
    begin
      in_region = ((addr & `REGION_MASK) == base) && (addr[1:0] == 2'h0);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Reset release
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Arbitration inputs
  reg [7:0] cand;
  reg [31:0] prio_vec;
  wire found;
  wire [2:0] win_idx;
  wire [3:0] win_prio;

  // Only enabled, flagged sources compete
  always @* begin
    for (i = 0; i < 8; i = i + 1) begin
      cand[i] = req_reg[i] & src_ctl_reg[i][`SC_ENABLE];
      prio_vec[i*4 +: 4] = src_ctl_reg[i][`SC_PRIO_MSB:`SC_PRIO_LSB];
    end
  end

  // Winner picked fresh every cycle
  prio_pick u_pick (
    .cand_i(cand),
    .prio_i(prio_vec),
    .found_o(found),
    .idx_o(win_idx),
    .prio_o(win_prio)
  );

  ////////////////////////////////////////////////////////////////////////
  // Service decision
  wire [15:0] win_ctl = src_ctl_reg[win_idx];
  wire [2:0] win_chan = win_ctl[`SC_CHAN_MSB:`SC_CHAN_LSB];
  wire [15:0] ch_ctl = chan_ctl_reg[win_chan];
  wire [7:0] ch_count = ch_ctl[`CC_COUNT_MSB:`CC_COUNT_LSB];
  wire ch_cont = ch_ctl[`CC_CONT];
  wire above = found && (win_prio > cpu_level_i);
  wire evt_route = win_ctl[`SC_EVT_SEL] && (ch_cont || ch_count != 8'h00);
  wire do_xfer = above && evt_route;
  wire do_cpu = above && !evt_route && !cpu_irq_o;
  wire take = cpu_irq_o && cpu_ack_i;
  wire [7:0] cnt_dec = ch_count - 8'h01;
  wire [15:0] step = ch_ctl[`CC_WORD] ? `STEP_WORD : `STEP_BYTE;
  wire last = !ch_cont && (cnt_dec == 8'h00);

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire acc_wr = avs_write_i && !avs_waitrequest_o;  // Write takes effect here
  wire [2:0] widx = avs_address_i[4:2];
  wire wr_src = acc_wr && in_region(avs_address_i, `SRC_CTL_BASE);
  wire wr_chan = acc_wr && in_region(avs_address_i, `CHAN_CTL_BASE);
  wire wr_sptr = acc_wr && in_region(avs_address_i, `SRC_PTR_BASE);
  wire wr_dptr = acc_wr && in_region(avs_address_i, `DST_PTR_BASE);
  wire wr_en = acc_wr && (avs_address_i == `IRQ_ENABLE_OFF);
  wire wr_clr = acc_wr && (avs_address_i == `IRQ_CLEAR_OFF);

  ////////////////////////////////////////////////////////////////////////
  // Request flags: software write, service clear, then event set
  always @* begin
    req_next = req_reg;
    if (wr_src && avs_byteenable_i[1]) begin
      req_next[widx] = avs_writedata_i[`SC_REQ];
    end
    if (do_xfer && !last) begin
      req_next[win_idx] = 1'b0;  // Moved, no CPU entry
    end
    if (take) begin
      req_next[cpu_vector_o] = 1'b0;  // Accepted by the CPU
    end
    req_next = req_next | evt_i;  // Set wins over any clear
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags: set wins over clear
  always @* begin
    status_next = status_reg;
    if (wr_clr && avs_byteenable_i[0]) begin
      status_next = status_next & ~avs_writedata_i[2:0];
    end
    if (do_xfer) begin
      status_next[`ST_XFER_DONE] = 1'b1;
    end
    if (do_xfer && last) begin
      status_next[`ST_COUNT_ZERO] = 1'b1;
    end
    if (take) begin
      status_next[`ST_CPU_TAKEN] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data mux
  always @* begin
    rdata_next = 32'h0000_0000;
    if (in_region(avs_address_i, `SRC_CTL_BASE)) begin
      rdata_next[15:0] = src_ctl_reg[widx];
      rdata_next[`SC_REQ] = req_reg[widx];
    end else if (in_region(avs_address_i, `CHAN_CTL_BASE)) begin
      rdata_next[15:0] = chan_ctl_reg[widx];
    end else if (in_region(avs_address_i, `SRC_PTR_BASE)) begin
      rdata_next[15:0] = src_ptr_reg[widx];
    end else if (in_region(avs_address_i, `DST_PTR_BASE)) begin
      rdata_next[15:0] = dst_ptr_reg[widx];
    end else if (avs_address_i == `IRQ_STATUS_OFF) begin
      rdata_next[2:0] = status_reg;
    end else if (avs_address_i == `IRQ_ENABLE_OFF) begin
      rdata_next[2:0] = enable_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, then an answer cycle
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end else if (!avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b1;  // Request accepted this edge
    end else if (avs_read_i || avs_write_i) begin
      avs_waitrequest_o <= 1'b0;  // Answer next cycle
      avs_readdata_o <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Source and channel registers
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (j = 0; j < 8; j = j + 1) begin
        src_ctl_reg[j] <= `SRC_CTL_RESET;
        chan_ctl_reg[j] <= `CHAN_CTL_RESET;
        src_ptr_reg[j] <= `PTR_RESET;
        dst_ptr_reg[j] <= `PTR_RESET;
      end
      req_reg <= 8'h00;
    end else begin
      req_reg <= req_next;
      // Channel update by a move
      if (do_xfer) begin
        if (!ch_cont) begin
          chan_ctl_reg[win_chan][`CC_COUNT_MSB:`CC_COUNT_LSB] <= cnt_dec;
        end
        if (ch_ctl[`CC_SRC_INC]) begin
          src_ptr_reg[win_chan] <= src_ptr_reg[win_chan] + step;
        end
        if (ch_ctl[`CC_DST_INC]) begin
          dst_ptr_reg[win_chan] <= dst_ptr_reg[win_chan] + step;
        end
      end
      // Software writes override a same-cycle move
      if (wr_src) begin
        src_ctl_reg[widx] <= merge_be(src_ctl_reg[widx], avs_writedata_i,
                                      avs_byteenable_i) & 16'h01FF;
      end
      if (wr_chan) begin
        chan_ctl_reg[widx] <= merge_be(chan_ctl_reg[widx], avs_writedata_i,
                                       avs_byteenable_i) & 16'h0FFF;
      end
      if (wr_sptr) begin
        src_ptr_reg[widx] <= merge_be(src_ptr_reg[widx], avs_writedata_i,
                                      avs_byteenable_i);
      end
      if (wr_dptr) begin
        dst_ptr_reg[widx] <= merge_be(dst_ptr_reg[widx], avs_writedata_i,
                                      avs_byteenable_i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Move strobe toward the memory path
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      xfer_valid_o <= 1'b0;
      xfer_src_o <= `PTR_RESET;
      xfer_dst_o <= `PTR_RESET;
      xfer_word_o <= 1'b0;
    end else begin
      xfer_valid_o <= do_xfer;  // Single cycle, no CPU involvement
      if (do_xfer) begin
        xfer_src_o <= src_ptr_reg[win_chan];
        xfer_dst_o <= dst_ptr_reg[win_chan];
        xfer_word_o <= ch_ctl[`CC_WORD];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // CPU interrupt request and acknowledge
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cpu_irq_o <= 1'b0;
      cpu_vector_o <= 3'h0;
      stack_push_o <= 1'b0;
    end else begin
      stack_push_o <= take;  // State saved on acceptance
      if (take) begin
        cpu_irq_o <= 1'b0;
      end else if (do_cpu) begin
        cpu_irq_o <= 1'b1;  // Forwarded above current level
        cpu_vector_o <= win_idx;  // Own vector, also after count zero
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Block status interrupt
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= `ST_RESET;
      enable_reg <= `ST_RESET;
      irq_o <= 1'b0;
    end else begin
      status_reg <= status_next;
      if (wr_en && avs_byteenable_i[0]) begin
        enable_reg <= avs_writedata_i[2:0];
      end
      irq_o <= |(status_next & enable_reg);
    end
  end

endmodule
`default_nettype wire

// ### event_irq_check_properties.sv
// Port-level assertions for the interrupt and event-transfer controller
`default_nettype none
module event_irq_check (
  input wire clk_i,              // CPU clock
  input wire rst_n_i,            // Raw reset, active low
  input wire avs_read_i,         // Read request
  input wire avs_write_i,        // Write request
  input wire avs_waitrequest_o,  // Bus stall
  input wire cpu_ack_i,          // CPU acceptance
  input wire cpu_irq_o,          // CPU request
  input wire [2:0] cpu_vector_o, // Requesting source
  input wire stack_push_o,       // State save pulse
  input wire xfer_valid_o        // Move strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////
  AST_WAIT_ONE: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("Bus access not answered after one wait cycle");
  AST_WAIT_SHORT: assert property (
    !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("Bus answer longer than one cycle");
  AST_WAIT_IDLE: assert property (
    !avs_read_i && !avs_write_i && avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("Bus answer without a request");
  AST_PUSH_AFTER_ACK: assert property (
    cpu_irq_o && cpu_ack_i |=> stack_push_o && !cpu_irq_o)
    else $error("Acceptance not followed by state save");
  AST_PUSH_CAUSE: assert property (
    stack_push_o |-> $past(cpu_irq_o) && $past(cpu_ack_i))
    else $error("State save without acceptance");
  AST_IRQ_HOLD: assert property (
    cpu_irq_o && !cpu_ack_i |=> cpu_irq_o && $stable(cpu_vector_o))
    else $error("Pending CPU request dropped or changed");
  AST_PUSH_ONE: assert property (
    stack_push_o |=> !stack_push_o)
    else $error("State save pulse too long");
  AST_ONE_ACTION: assert property (
    xfer_valid_o |-> !$rose(cpu_irq_o))
    else $error("Move and CPU request in one cycle");
  // Main scenarios
  cover property (xfer_valid_o);
  cover property (stack_push_o);
  cover property (cpu_irq_o && !cpu_ack_i ##1 cpu_irq_o);
endmodule
bind event_irq_ctrl event_irq_check check_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .cpu_ack_i(cpu_ack_i), .cpu_irq_o(cpu_irq_o), .cpu_vector_o(cpu_vector_o),
  .stack_push_o(stack_push_o), .xfer_valid_o(xfer_valid_o));
`default_nettype wire

// ### event_cpu_peer.sv
// Model of the peripheral request sources and the CPU core
`default_nettype none
module event_cpu_peer (
  input wire logic clk_i,       // CPU clock
  input wire logic rst_n_i,     // Reset, active low
  input wire logic cpu_irq_i,   // Pending CPU request
  input wire logic hold_i,      // CPU refuses to accept
  input wire logic [3:0] gap_i, // Cycles before acceptance
  output var logic [7:0] evt_o, // Request pulses
  output var logic cpu_ack_o    // Acceptance strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_reg; // Cycles waited so far
  initial evt_o = 8'h00;
  ////////////////////////////////////////////////////////////////////////////
  // One-cycle request pulse on every set bit
  task automatic pulse(input logic [7:0] m);
    @(posedge clk_i);
    evt_o <= m;
    @(posedge clk_i);
    evt_o <= 8'h00;
  endtask
  // Accepts a pending request promptly or slowly, one-cycle strobe
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_reg <= 4'h0;
      cpu_ack_o <= 1'b0;
    end else if (cpu_irq_i && !cpu_ack_o && !hold_i) begin
      if (wait_reg == gap_i) begin
        cpu_ack_o <= 1'b1;
        wait_reg <= 4'h0;
      end else begin
        wait_reg <= wait_reg + 4'h1;
      end
    end else begin
      cpu_ack_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### event_irq_ctrl_bench.sv
// Self-checking bench for the interrupt and event-transfer controller
`default_nettype none
module event_irq_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_n_i, rd, wr, ack, cpu_irq, push, xv, xw, irq, hold, wait_req;
  logic [7:0] addr, evt;
  logic [31:0] wdata, rdata, got;
  logic [3:0] level, gap;
  logic [2:0] vec;
  logic [15:0] xs, xd;
  int mismatches = 0, cmp_count = 0, cycles = 0, i;
  ////////////////////////////////////////////////////////////////////////////
  event_irq_ctrl dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req), .evt_i(evt), .cpu_level_i(level),
    .cpu_ack_i(ack), .cpu_irq_o(cpu_irq), .cpu_vector_o(vec), .stack_push_o(push),
    .xfer_valid_o(xv), .xfer_src_o(xs), .xfer_dst_o(xd), .xfer_word_o(xw), .irq_o(irq));
  event_cpu_peer peer_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .cpu_irq_i(cpu_irq),
    .hold_i(hold), .gap_i(gap), .evt_o(evt), .cpu_ack_o(ack));
  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Value comparison
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    // Ends when waitrequest is sampled low; the hang guard ends a stuck wait
    do begin
      @(posedge clk_i);
    end while (wait_req !== 1'b0);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(got, e);
  endtask
  // Bounded wait: 0 move strobe, 1 CPU request, 2 state save
  task automatic wait_hi(input int k);
    int n;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_i);
      if ((k == 0 && xv === 1'b1) || (k == 1 && cpu_irq === 1'b1) ||
          (k == 2 && push === 1'b1)) break;
    end
    if (n == 40) mismatches++;
  endtask
  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      complete_run;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n_i = 1'b0;
    {rd, wr, hold} = 3'h0;
    addr = 8'h00;
    wdata = 32'h0;
    level = 4'h0;
    gap = 4'h2;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    // Reset values, reserved bits, unmapped and write-only places
    rd_chk(8'h20, 32'h0);
    rd_chk(8'h80, 32'h0);
    wr_reg(8'h00, 32'h7E35);
    rd_chk(8'h00, 32'h0035);
    wr_reg(8'h8C, 32'hFFFF);
    rd_chk(8'h8C, 32'h0);
    rd_chk(8'h88, 32'h0);
    // Word moves on channel 0 until the count runs out
    hold <= 1'b1;
    wr_reg(8'h20, 32'h0502);
    wr_reg(8'h40, 32'h1000);
    wr_reg(8'h60, 32'h2000);
    for (i = 0; i < 2; i++) begin
      peer_u.pulse(8'h01);
      wait_hi(0);
      chk(xs, 32'h1000 + 32'h2 * i);
      chk(xd, 32'h2000);
      chk(xw, 32'h1);
      rd_chk(8'h20, 32'h0501 - i);
    end
    wait_hi(1);
    chk(vec, 32'h0);
    hold <= 1'b0;
    wait_hi(2);
    rd_chk(8'h40, 32'h1004);
    rd_chk(8'h80, 32'h7);
    // Status interrupt raised, masked, unmasked and cleared
    wr_reg(8'h84, 32'h7);
    repeat (2) @(posedge clk_i);
    chk(irq, 32'h1);
    wr_reg(8'h84, 32'h0);
    repeat (2) @(posedge clk_i);
    chk(irq, 32'h0);
    wr_reg(8'h84, 32'h1);
    repeat (2) @(posedge clk_i);
    chk(irq, 32'h1);
    wr_reg(8'h88, 32'h7);
    repeat (2) @(posedge clk_i);
    chk(irq, 32'h0);
    rd_chk(8'h80, 32'h0);
    // Continuous byte moves on channel 1, count left alone
    gap <= 4'h0;
    wr_reg(8'h10, 32'h0072);
    wr_reg(8'h24, 32'h0A01);
    wr_reg(8'h64, 32'h3000);
    for (i = 0; i < 2; i++) begin
      peer_u.pulse(8'h10);
      wait_hi(0);
      chk(xd, 32'h3000 + i);
      chk(xw, 32'h0);
    end
    rd_chk(8'h24, 32'h0A01);
    chk(cpu_irq, 32'h0);
    // CPU service against the level, enable and priority order
    level <= 4'h7;
    hold <= 1'b1;
    wr_reg(8'h04, 32'h0013);
    wr_reg(8'h08, 32'h0017);
    wr_reg(8'h0C, 32'h0009);
    peer_u.pulse(8'h0E);
    repeat (6) @(posedge clk_i);
    chk(cpu_irq, 32'h0);
    rd_chk(8'h0C, 32'h8009);
    rd_chk(8'h04, 32'h8013);
    level <= 4'h5;
    wait_hi(1);
    chk(vec, 32'h2);
    hold <= 1'b0;
    wait_hi(2);
    rd_chk(8'h08, 32'h0017);
    repeat (4) @(posedge clk_i);
    chk(cpu_irq, 32'h0);
    level <= 4'h2;
    wait_hi(1);
    chk(vec, 32'h1);
    wait_hi(2);
    rd_chk(8'h04, 32'h0013);
    complete_run;
  end
endmodule
`default_nettype wire
